// *** onchip_peripheral_bus_decode_pkg.sv ***
// constants and types for the peripheral bus address decoder
package onchip_peripheral_bus_decode_pkg;
    // ==========================================================
    // register map (byte addresses on apb)
    localparam logic [15:0] SEL_OFFS = 16'hf024;
    localparam logic [15:0] CFG_OFFS = 16'hf028;
    localparam logic [15:0] RTCC_OFFS = 16'hf02c;
    localparam logic [15:0] STAT_OFFS = 16'hf030;
    // ==========================================================
    // select register fields
    localparam int SEL_W = 5;
    localparam int B_CAN1 = 0;
    localparam int B_CAN2 = 1;
    localparam int B_SRAM = 2;
    localparam int B_LRAM = 3;
    localparam int B_RTC = 4;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h05;
    localparam logic [SEL_W-1:0] SEL_ALL = 5'h1f;
    // system config fields
    localparam int C_REMAP = 1;
    localparam int C_GLOBAL = 2;
    localparam int C_END_INIT_INSTRUCTION = 3;
    // clock control field
    localparam int R_OSCPD = 0;
    // status fields
    localparam int S_END_INIT_INSTRUCTION = 5;
    localparam int S_EMU = 6;
    // ==========================================================
    // address windows
    localparam logic [23:0] SRAM_LO = 24'h00_e000;
    localparam logic [23:0] SRAM_HI = 24'h00_e7ff;
    localparam logic [23:0] LRAM_LO = 24'h00_c000;
    localparam logic [23:0] LRAM_HI = 24'h00_dfff;
    localparam logic [23:0] CAN1_LO = 24'h00_ef00;
    localparam logic [23:0] CAN1_HI = 24'h00_efff;
    localparam logic [23:0] CAN2_LO = 24'h00_ee00;
    localparam logic [23:0] CAN2_HI = 24'h00_eeff;
    localparam logic [23:0] RTC_LO = 24'h00_ec00;
    localparam logic [23:0] RTC_HI = 24'h00_ecff;
    localparam logic [23:0] BANK_HI = 24'h00_7fff;
    localparam logic [23:0] SEG_STEP = 24'h01_0000;
    // ==========================================================
    // timing
    localparam int CLK_MHZ = 40;
    localparam int CAN_ACCESS_NS = 125;
    localparam int CAN_ACC_CYC = (CAN_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0] CAN_WAIT_ST = 2'h2;
    localparam logic [3:0] SEG_LINES_CAN = 4'h4;
    localparam logic [3:0] SEG_LINES_FULL = 4'h8;
    // ==========================================================
    // types
    typedef enum logic [2:0] {
        TGT_NONE, TGT_CORE, TGT_SRAM, TGT_LRAM,
        TGT_CAN1, TGT_CAN2, TGT_RTC, TGT_EXT
    } target_e;
    typedef enum logic [1:0] {
        KIND_DATA, KIND_STACK, KIND_REGBANK, KIND_BIT
    } access_kind_e;
    typedef struct packed {
        logic valid;
        logic write;
        logic byte_acc;
        access_kind_e kind;
        logic [23:0] addr;
    } cpu_req_s;
    typedef struct packed {
        target_e tgt;
        logic [1:0] wait_st;
        logic write;
        logic byte_acc;
        logic [23:0] phys;
    } route_s;
endpackage : onchip_peripheral_bus_decode_pkg

// *** onchip_peripheral_bus_peripheral_address_decode.sv ***
// address decode and enable logic of the on-chip peripheral bus
`timescale 1ns/1ps
module onchip_peripheral_bus_peripheral_address_decode
    import onchip_peripheral_bus_decode_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cpu_req_s cpu_req,
    input wire logic emu_mode_pin,
    input wire logic powerdown_pin,
    output route_s route,
    output logic cpu_busy,
    output logic acc_done,
    output logic acc_error,
    output logic [1:0] can_pins_claimed,
    output logic [1:0] can_irq_enable,
    output logic [3:0] seg_lines,
    output logic osc_stop
);
    // ==========================================================
    // pin synchronisers
    logic emu_m_q, emu_q; // emulation strap, two stages
    logic pd_m_q, pd_q; // power-down request, two stages

    // only the second stage is read by the logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emu_m_q <= 1'b0;
            emu_q <= 1'b0;
            pd_m_q <= 1'b0;
            pd_q <= 1'b0;
        end else begin
            emu_m_q <= emu_mode_pin;
            emu_q <= emu_m_q;
            pd_m_q <= powerdown_pin;
            pd_q <= pd_m_q;
        end
    end

    // ==========================================================
    // apb slave
    logic [SEL_W-1:0] sel_q; // peripheral select bits
    logic global_q; // global peripheral enable, set-only
    logic remap_q; // flash bank remap
    logic end_init_instruction_q; // end of init seen
    logic oscpd_q; // oscillator power-down choice
    logic wr_en; // write takes effect this edge
    logic mapped; // address hits a register
    logic [31:0] rd_d; // read mux
    logic [SEL_W-1:0] eff; // effective enables

    assign wr_en = psel && penable && pready && pwrite;

    // read mux, unused bits zero
    always_comb begin
        rd_d = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            SEL_OFFS: rd_d[SEL_W-1:0] = sel_q;
            CFG_OFFS: begin
                rd_d[C_REMAP] = remap_q;
                rd_d[C_GLOBAL] = global_q;
            end
            RTCC_OFFS: rd_d[R_OSCPD] = oscpd_q;
            STAT_OFFS: begin
                rd_d[SEL_W-1:0] = eff;
                rd_d[S_END_INIT_INSTRUCTION] = end_init_instruction_q;
                rd_d[S_EMU] = emu_q;
            end
            default: mapped = 1'b0;
        endcase
    end

    // one wait-free access phase: ready rises in the first access
    // cycle, so every transfer is setup plus one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= !mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // select register; frozen once the global enable is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= SEL_RESET;
        end else if (wr_en && paddr == SEL_OFFS && !global_q) begin
            sel_q <= pwdata[SEL_W-1:0];
        end
    end

    // system config: global enable cannot be withdrawn, since
    // the peripheral map must not change under running code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_q <= 1'b0;
            remap_q <= 1'b0;
            end_init_instruction_q <= 1'b0;
        end else if (wr_en && paddr == CFG_OFFS) begin
            if (pwdata[C_GLOBAL]) begin
                global_q <= 1'b1;
            end
            // remap only changes before end of init
            if (!end_init_instruction_q) begin
                remap_q <= pwdata[C_REMAP];
            end
            if (pwdata[C_END_INIT_INSTRUCTION]) begin
                end_init_instruction_q <= 1'b1;
            end
        end
    end

    // clock control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oscpd_q <= 1'b0;
        end else if (wr_en && paddr == RTCC_OFFS) begin
            oscpd_q <= pwdata[R_OSCPD];
        end
    end

    // ==========================================================
    // effective enables
    // emulation overrides the programmed selects entirely
    assign eff = emu_q ? SEL_ALL : (global_q ? sel_q : '0);

    // ==========================================================
    // address decode
    logic [23:0] a; // request address
    target_e tgt_d; // decoded target
    logic err_d; // illegal use of extension ram
    logic [23:0] phys_d; // address after remap
    logic in_sram, in_lram, in_can1, in_can2, in_rtc;
    logic no_can; // both can controllers off

    assign a = cpu_req.addr;
    assign in_sram = a >= SRAM_LO && a <= SRAM_HI;
    assign in_lram = a >= LRAM_LO && a <= LRAM_HI;
    assign in_can1 = a >= CAN1_LO && a <= CAN1_HI;
    assign in_can2 = a >= CAN2_LO && a <= CAN2_HI;
    assign in_rtc = a >= RTC_LO && a <= RTC_HI;
    assign no_can = !eff[B_CAN1] && !eff[B_CAN2];

    // windows are disjoint, so the order only matters for
    // readability; disabled can and clock windows fall dead
    // unless every can is off, keeping the 4-line bus intact
    always_comb begin
        tgt_d = TGT_CORE;
        if (in_sram) begin
            tgt_d = eff[B_SRAM] ? TGT_SRAM : TGT_EXT;
        end else if (in_lram) begin
            tgt_d = eff[B_LRAM] ? TGT_LRAM : TGT_EXT;
        end else if (in_can1) begin
            if (eff[B_CAN1]) begin
                tgt_d = TGT_CAN1;
            end else begin
                tgt_d = no_can ? TGT_EXT : TGT_NONE;
            end
        end else if (in_can2) begin
            if (eff[B_CAN2]) begin
                tgt_d = TGT_CAN2;
            end else begin
                tgt_d = no_can ? TGT_EXT : TGT_NONE;
            end
        end else if (in_rtc) begin
            if (eff[B_RTC]) begin
                tgt_d = TGT_RTC;
            end else begin
                tgt_d = no_can ? TGT_EXT : TGT_NONE;
            end
        end
    end

    // extension ram behaves as external memory: no stack, no
    // register bank, no single-bit operation
    always_comb begin
        err_d = 1'b0;
        if (tgt_d == TGT_SRAM || tgt_d == TGT_LRAM) begin
            err_d = cpu_req.kind != KIND_DATA;
        end
    end

    // lowest flash bank moves up one segment when remapped
    always_comb begin
        phys_d = a;
        if (remap_q && a <= BANK_HI) begin
            phys_d = a + SEG_STEP;
        end
    end

    // ==========================================================
    // access sequencer
    typedef enum logic {ACC_IDLE, ACC_BUSY} acc_state_e;
    acc_state_e st_q; // sequencer state
    logic [3:0] cnt_q; // remaining wait cycles
    logic take; // request accepted this edge

    assign take = cpu_req.valid && st_q == ACC_IDLE;

    // route word held for the whole access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route <= '0;
        end else if (take) begin
            route.tgt <= err_d ? TGT_NONE : tgt_d;
            route.write <= cpu_req.write;
            route.byte_acc <= cpu_req.byte_acc;
            route.phys <= phys_d;
            if (tgt_d == TGT_CAN1 || tgt_d == TGT_CAN2) begin
                route.wait_st <= CAN_WAIT_ST;
            end else begin
                route.wait_st <= 2'h0;
            end
        end
    end

    // ram and everything else finish one cycle after the
    // route; a can access spans its full access time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ACC_IDLE;
            cnt_q <= 4'h0;
            acc_done <= 1'b0;
            acc_error <= 1'b0;
            cpu_busy <= 1'b0;
        end else begin
            acc_done <= 1'b0;
            case (st_q)
                ACC_IDLE: begin
                    if (take) begin
                        st_q <= ACC_BUSY;
                        cpu_busy <= 1'b1;
                        acc_error <= err_d;
                        if (!err_d && (tgt_d == TGT_CAN1 ||
                                       tgt_d == TGT_CAN2)) begin
                            cnt_q <= 4'(CAN_ACC_CYC - 1);
                        end else begin
                            cnt_q <= 4'h0;
                        end
                    end
                end
                ACC_BUSY: begin
                    if (cnt_q == 4'h0) begin
                        st_q <= ACC_IDLE;
                        cpu_busy <= 1'b0;
                        acc_done <= 1'b1;
                        acc_error <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: st_q <= ACC_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pin, interrupt and segment claims
    // a can disabled before the global enable claims its pins or
    // interrupts only in emulation; the lock keeps that state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            can_pins_claimed <= 2'h0;
            can_irq_enable <= 2'h0;
            seg_lines <= SEG_LINES_FULL;
        end else begin
            can_pins_claimed <= {eff[B_CAN2], eff[B_CAN1]};
            can_irq_enable <= {eff[B_CAN2], eff[B_CAN1]};
            seg_lines <= no_can ? SEG_LINES_FULL
                                : SEG_LINES_CAN;
        end
    end

    // oscillator: forced off in power-down when the clock is
    // disabled, otherwise the control bit chooses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_stop <= 1'b0;
        end else begin
            osc_stop <= pd_q && (!eff[B_RTC] || oscpd_q);
        end
    end

    // ==========================================================
    // checks
    chk_sel_lock: assert property (@(posedge pclk)
        disable iff (!presetn) global_q |=> $stable(sel_q))
        else $error("select changed after global enable");

    chk_sel_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready && paddr == SEL_OFFS && !pwrite |-> prdata[31:5] == 0)
        else $error("reserved select bits not zero");

    chk_sram_map: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && in_sram && eff[B_SRAM] && cpu_req.kind == KIND_DATA
        |=> route.tgt == TGT_SRAM)
        else $error("small ram not routed");

    chk_lram_ext: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && in_lram && !eff[B_LRAM] |=> route.tgt == TGT_EXT)
        else $error("large ram range not external");

    chk_can1_dead: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && in_can1 && !eff[B_CAN1] && eff[B_CAN2]
        |=> route.tgt == TGT_NONE)
        else $error("disabled can window not dead");

    chk_can_wait: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && !err_d && tgt_d == TGT_CAN2
        |=> !acc_done [*5] ##1 acc_done)
        else $error("can access time wrong");

    chk_ram_fast: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && tgt_d == TGT_SRAM |=> ##1 acc_done)
        else $error("ram access not zero wait");

    chk_ram_misuse: assert property (@(posedge pclk)
        disable iff (!presetn)
        take && in_lram && eff[B_LRAM] && cpu_req.kind == KIND_BIT
        |=> acc_error && route.tgt == TGT_NONE)
        else $error("bit access to extension ram");

    chk_emu_all: assert property (@(posedge pclk)
        disable iff (!presetn) emu_q |-> eff == SEL_ALL)
        else $error("emulation does not enable all");

    chk_seg_lines: assert property (@(posedge pclk)
        disable iff (!presetn)
        !no_can |=> seg_lines == SEG_LINES_CAN)
        else $error("segment lines not limited");

    chk_osc_stop: assert property (@(posedge pclk)
        disable iff (!presetn)
        pd_q && !eff[B_RTC] |=> osc_stop)
        else $error("oscillator not stopped");

    chk_remap_lock: assert property (@(posedge pclk)
        disable iff (!presetn) end_init_instruction_q |=> $stable(remap_q))
        else $error("remap changed after end of init");

endmodule : onchip_peripheral_bus_peripheral_address_decode

// *** cpu_model.sv ***
// cpu side model: issues one access at a time and watches its result
`timescale 1ns/1ps
module cpu_model
    import onchip_peripheral_bus_decode_pkg::*;
(
    input wire logic pclk,
    input wire logic cpu_busy,
    input wire logic acc_done,
    input wire logic acc_error,
    input wire route_s route,
    output cpu_req_s cpu_req
);
    // ==========================================================
    // access sequencer
    // idle value is the inverse of the last request, so a stale
    // address or kind can never pass for a live request
    initial begin
        cpu_req = '0;
    end

    // lat is one more than the cycles from the take edge to the done pulse
    task automatic do_access(input cpu_req_s r, output route_s rt,
        output logic err, output logic bsy, output int lat);
        int n;
        lat = -1;
        cpu_req <= r;
        // design is idle, so the next edge takes the request
        @(posedge pclk);
        cpu_req <= ~r;
        @(negedge pclk);
        rt = route;
        err = acc_error;
        // busy must already stand in the first cycle after the take
        bsy = cpu_busy;
        // bounded wait for the done pulse
        for (n = 1; n <= 20; n++) begin
            if (acc_done === 1'b1) begin
                lat = n;
                break;
            end
            @(negedge pclk);
        end
        @(posedge pclk);
    endtask : do_access
endmodule : cpu_model

// *** tb_top.sv ***
// self-checking testbench for the peripheral bus address decoder
`timescale 1ns/1ps
module tb_top
    import onchip_peripheral_bus_decode_pkg::*;
;
    // ==========================================================
    // signals
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    cpu_req_s cpu_req;
    logic emu_mode_pin;
    logic powerdown_pin;
    route_s route;
    logic cpu_busy;
    logic acc_done;
    logic acc_error;
    logic [1:0] can_pins_claimed;
    logic [1:0] can_irq_enable;
    logic [3:0] seg_lines;
    logic osc_stop;
    int failures = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic er;

    // ==========================================================
    // instances
    onchip_peripheral_bus_peripheral_address_decode dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req(cpu_req), .emu_mode_pin(emu_mode_pin),
        .powerdown_pin(powerdown_pin), .route(route), .cpu_busy(cpu_busy),
        .acc_done(acc_done), .acc_error(acc_error),
        .can_pins_claimed(can_pins_claimed),
        .can_irq_enable(can_irq_enable), .seg_lines(seg_lines),
        .osc_stop(osc_stop));
    cpu_model cpu_u (.pclk(pclk), .cpu_busy(cpu_busy),
        .acc_done(acc_done), .acc_error(acc_error), .route(route),
        .cpu_req(cpu_req));

    // 25 ns clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ==========================================================
    // helpers
    task automatic test_done();
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] s, input logic [31:0] x,
        input string m);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, m, s, x);
        end
    endtask : chk

    // one apb transfer; entered right after a rising edge
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // request stays put until pready is sampled high at an edge
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            failures++;
            test_done();
        end
        // read data and error are taken at the ready edge itself
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle keeps back-to-back calls from driving
        // the strobes twice in one time step
        @(posedge pclk);
    endtask : apb

    // one cpu access; wait and latency follow from the target, error from target and kind
    task automatic acc(input logic [23:0] a, input access_kind_e k,
        input logic b, input target_e t, input logic [23:0] off);
        cpu_req_s r;
        route_s rt;
        logic e;
        logic bsy;
        int lat;
        logic can;
        // byte accesses double as writes so the direction bit moves
        r = '{valid: 1'h1, write: b, byte_acc: b, kind: k, addr: a};
        can = (t == TGT_CAN1 || t == TGT_CAN2);
        cpu_u.do_access(r, rt, e, bsy, lat);
        if (lat < 0) begin
            failures++;
            test_done();
        end
        chk(rt.tgt, t, "target");
        chk(rt.phys, a + off, "phys");
        chk(rt.byte_acc, b, "byte");
        chk(rt.write, b, "write");
        chk(bsy, 1'h1, "busy");
        chk(rt.wait_st, can ? CAN_WAIT_ST : 2'h0, "wait");
        chk(lat, can ? CAN_ACC_CYC + 1 : 2, "latency");
        chk(e, t == TGT_NONE && k != KIND_DATA, "error");
    endtask : acc

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        emu_mode_pin = 1'b0;
        powerdown_pin = 1'b0;
        repeat (2) @(posedge pclk);
        chk(route, 32'h0000_0000, "reset route");
        chk(seg_lines, 4'h8, "reset seg");
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, SEL_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0005, "sel reset");
        apb(1'b0, 16'hf000, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001, "unmapped");
        // global enable still clear: both rams, the first can and the clock window go out
        acc(24'h00_e000, KIND_DATA, 1'h0, TGT_EXT, 24'h0);
        acc(24'h00_c000, KIND_DATA, 1'h0, TGT_EXT, 24'h0);
        acc(24'h00_ef00, KIND_DATA, 1'h0, TGT_EXT, 24'h0);
        acc(24'h00_ec00, KIND_DATA, 1'h0, TGT_EXT, 24'h0);
        apb(1'b1, SEL_OFFS, 32'hffff_ffff);
        apb(1'b0, SEL_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_001f, "sel high bits");
        // first can and large ram only, then remap and global enable
        apb(1'b1, SEL_OFFS, 32'h0000_0009);
        apb(1'b1, CFG_OFFS, 32'h0000_0006);
        apb(1'b0, CFG_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0006, "config");
        chk(can_pins_claimed, 2'h1, "pins");
        chk(can_irq_enable, 2'h1, "irq");
        chk(seg_lines, SEG_LINES_CAN, "seg");
        acc(24'h00_e7ff, KIND_DATA, 1'h0, TGT_EXT, 24'h0);
        acc(24'h00_c000, KIND_DATA, 1'h1, TGT_LRAM, 24'h0);
        acc(24'h00_dfff, KIND_DATA, 1'h0, TGT_LRAM, 24'h0);
        acc(24'h00_c002, KIND_STACK, 1'h0, TGT_NONE, 24'h0);
        acc(24'h00_c004, KIND_REGBANK, 1'h0, TGT_NONE, 24'h0);
        acc(24'h00_c006, KIND_BIT, 1'h0, TGT_NONE, 24'h0);
        acc(24'h00_ef00, KIND_DATA, 1'h1, TGT_CAN1, 24'h0);
        acc(24'h00_efff, KIND_DATA, 1'h0, TGT_CAN1, 24'h0);
        acc(24'h00_ee00, KIND_DATA, 1'h0, TGT_NONE, 24'h0);
        acc(24'h00_ec00, KIND_DATA, 1'h0, TGT_NONE, 24'h0);
        acc(24'h00_e800, KIND_DATA, 1'h0, TGT_CORE, 24'h0);
        // end of init, then a late attempt to clear the remap bit
        apb(1'b1, CFG_OFFS, 32'h0000_000e);
        apb(1'b1, CFG_OFFS, 32'h0000_0004);
        acc(24'h00_1234, KIND_DATA, 1'h0, TGT_CORE, SEG_STEP);
        // the select register is frozen now
        apb(1'b1, SEL_OFFS, 32'h0000_001f);
        apb(1'b0, SEL_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0009, "sel locked");
        // clock disabled: power-down stops the oscillator
        powerdown_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(osc_stop, 1'h1, "osc stop");
        powerdown_pin <= 1'b0;
        // emulation forces every peripheral on
        emu_mode_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        acc(24'h00_e000, KIND_DATA, 1'h0, TGT_SRAM, 24'h0);
        acc(24'h00_ee00, KIND_DATA, 1'h0, TGT_CAN2, 24'h0);
        acc(24'h00_ec00, KIND_DATA, 1'h0, TGT_RTC, 24'h0);
        apb(1'b0, STAT_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_007f, "status");
        // clock enabled: the control bit now decides the stop
        powerdown_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(osc_stop, 1'h0, "osc kept");
        apb(1'b1, RTCC_OFFS, 32'h0000_0001);
        apb(1'b0, RTCC_OFFS, 32'h0000_0000);
        chk(rd, 32'h0000_0001, "osc choice");
        chk(osc_stop, 1'h1, "osc chosen");
        test_done();
    end
endmodule : tb_top
